// [rtl/dmba_pkg.sv]
// dmba_pkg.sv: constants and carrier types of the banked data memory addressing block
// Shared by the top module, the address former and the storage module
package dmba_pkg;

	// Address geometry
	localparam int unsigned ADDR_W    = 12;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned OFF_W     = 8;
	localparam int unsigned BANK_W    = 4;
	localparam int unsigned NUM_BANKS = 16;

	// Common region: low half of bank 0, then high half of bank 15
	localparam logic [OFF_W-1:0]  COMMON_SPLIT   = 8'h80;
	localparam logic [BANK_W-1:0] COMMON_LO_BANK = 4'h0;
	localparam logic [BANK_W-1:0] COMMON_HI_BANK = 4'hf;

	// Implemented banks; RAM_SLOTS must equal the number of ones in the mask
	localparam logic [NUM_BANKS-1:0] BANK_IMPL_MASK = 16'h8003;
	localparam int unsigned          RAM_SLOTS      = 3;
	localparam int unsigned          SLOT_W         = 2;
	localparam int unsigned          RAM_BYTES      = RAM_SLOTS * 256;
	localparam int unsigned          RAM_IDX_W      = 10;

	// Bank select register
	localparam logic [7:0] BANK_SEL_RST  = 8'h00;
	localparam logic [7:0] BANK_SEL_MASK = 8'h0f;

	// Arithmetic status flags
	localparam int unsigned     FLAGS_W   = 5;
	localparam logic [FLAGS_W-1:0] FLAGS_RST = 5'h00;

	// Access counters
	localparam int unsigned CNT_W = 16;

	// APB register byte offsets
	localparam logic [11:0] REG_BANK_SEL   = 12'h000;
	localparam logic [11:0] REG_STATUS     = 12'h004;
	localparam logic [11:0] REG_LAST_ADDR  = 12'h008;
	localparam logic [11:0] REG_WIN_ADDR   = 12'h00c;
	localparam logic [11:0] REG_WIN_DATA   = 12'h010;
	localparam logic [11:0] REG_ACC_CNT    = 12'h014;
	localparam logic [11:0] REG_UNIMPL_CNT = 12'h018;
	localparam logic [11:0] REG_FLAGS      = 12'h01c;

	typedef enum logic [1:0] {
		op_read,
		op_write,
		op_file_move,
		op_load_bank
	} dmba_op_t;

	typedef struct packed {
		logic               valid;
		dmba_op_t           op;
		logic               use_bank;
		logic [OFF_W-1:0]   offset;
		logic [ADDR_W-1:0]  src;
		logic [ADDR_W-1:0]  dst;
		logic [DATA_W-1:0]  wdata;
		logic [7:0]         lit;
		logic               flags_we;
		logic [FLAGS_W-1:0] flags;
	} dmba_req_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] rdata;
		logic              unimpl;
	} dmba_rsp_t;

endpackage

// [rtl/dmba_addr.sv]
// dmba_addr.sv: forms the 12-bit operand address from offset, access bit and bank
// Purely combinational; the caller registers whatever leaves the block
`timescale 1ns/100ps
module dmba_addr
	import dmba_pkg::*;
(
	// Operand
	input  wire logic              use_bank_i,
	input  wire logic [OFF_W-1:0]  offset_i,
	input  wire logic [BANK_W-1:0] bank_i,
	// Address
	output logic [ADDR_W-1:0]      addr_o
);

	always_comb
	begin
		if (use_bank_i)
			addr_o = {bank_i, offset_i};
		else if (offset_i < COMMON_SPLIT)
			addr_o = {COMMON_LO_BANK, offset_i};
		else
			addr_o = {COMMON_HI_BANK, offset_i};
	end

endmodule

// [rtl/dmba_ram.sv]
// dmba_ram.sv: flip-flop storage for the implemented banks only
// One combinational read port and one write port; both on the same 12-bit space
`timescale 1ns/100ps
module dmba_ram
	import dmba_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	// Read port
	input  wire logic [ADDR_W-1:0] rd_addr_i,
	output logic [DATA_W-1:0]      rd_data_o,
	output logic                   rd_impl_o,
	// Write port
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] wr_addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	output logic                   wr_impl_o
);

	logic [DATA_W-1:0]    mem_q [RAM_BYTES];
	logic [RAM_IDX_W-1:0] rd_idx;
	logic [RAM_IDX_W-1:0] wr_idx;

	// Packs implemented banks densely so no storage is spent on absent ones
	function automatic logic [SLOT_W-1:0] slot_of(input logic [BANK_W-1:0] bank);
		logic [SLOT_W-1:0] n;
		n = '0;
		for (int b = 0; b < NUM_BANKS; b++)
			if (b < int'(bank) && BANK_IMPL_MASK[b])
				n = n + 1'b1;
		return n;
	endfunction

	assign rd_impl_o = BANK_IMPL_MASK[rd_addr_i[ADDR_W-1 -: BANK_W]];
	assign wr_impl_o = BANK_IMPL_MASK[wr_addr_i[ADDR_W-1 -: BANK_W]];
	assign rd_idx    = {slot_of(rd_addr_i[ADDR_W-1 -: BANK_W]), rd_addr_i[OFF_W-1:0]};
	assign wr_idx    = {slot_of(wr_addr_i[ADDR_W-1 -: BANK_W]), wr_addr_i[OFF_W-1:0]};
	assign rd_data_o = rd_impl_o ? mem_q[rd_idx] : '0;

	genvar i;
	generate
		for (i = 0; i < RAM_BYTES; i++)
		begin : g_byte
			always_ff @(posedge mclk_i)
			begin
				if (rst_i)
					mem_q[i] <= '0;
				else if (we_i && wr_impl_o && wr_idx == RAM_IDX_W'(i))
					mem_q[i] <= wdata_i;
			end
		end
	endgenerate

endmodule

// [rtl/dmba_top.sv]
// dmba_top.sv: banked data memory addressing, storage and APB register access
// Assumes the decode stage offers at most one request per cycle on req_i,
// synchronous to mclk_i, and an APB master on the same clock.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module dmba_top
	import dmba_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	// APB slave
	input  wire logic [11:0] paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Decode stage requests and answers
	input  wire dmba_req_t   req_i,
	output dmba_rsp_t        rsp_o,
	// Visible state
	output logic [7:0]       bank_select_o,
	output logic [FLAGS_W-1:0] status_flags_o
);

	typedef enum logic [1:0] {
		ap_idle,
		ap_wait,
		ap_resp
	} dmba_ap_state_t;

	// Registers
	dmba_ap_state_t     ap_state_q;
	dmba_ap_state_t     ap_state_d;
	logic [7:0]         bank_select_q;
	logic [FLAGS_W-1:0] flags_q;
	dmba_rsp_t          rsp_q;
	logic [ADDR_W-1:0]  win_addr_q;
	logic [CNT_W-1:0]   acc_cnt_q;
	logic [CNT_W-1:0]   unimpl_cnt_q;
	logic [31:0]        prdata_q;
	logic               pready_q;
	logic               pslverr_q;

	// Address forming and storage port
	logic [ADDR_W-1:0]  oper_addr;
	logic [ADDR_W-1:0]  rd_addr;
	logic [ADDR_W-1:0]  wr_addr;
	logic [DATA_W-1:0]  wr_data;
	logic               wr_en;
	logic [DATA_W-1:0]  rd_data;
	logic               rd_impl;
	logic               wr_impl;

	// APB decode
	logic               apb_req;
	logic               apb_go;
	logic               apb_wr;
	logic               is_win;
	logic               mapped;
	logic [31:0]        rd_mux;
	logic               core_acc;
	logic               core_unimpl;

	// The access bit picks the banked or the common region
	dmba_addr u_addr
	(
		.use_bank_i (req_i.use_bank),
		.offset_i   (req_i.offset),
		.bank_i     (bank_select_q[BANK_W-1:0]),
		.addr_o     (oper_addr)
	);

	dmba_ram u_ram
	(
		.mclk_i    (mclk_i),
		.rst_i     (rst_i),
		.rd_addr_i (rd_addr),
		.rd_data_o (rd_data),
		.rd_impl_o (rd_impl),
		.we_i      (wr_en),
		.wr_addr_i (wr_addr),
		.wdata_i   (wr_data),
		.wr_impl_o (wr_impl)
	);

	// An APB request stays pending until its answer has been sampled
	assign apb_req = psel_i && penable_i && (ap_state_q != ap_resp);
	assign is_win  = (paddr_i == REG_WIN_DATA);

	// The core owns the storage port; a window access waits for a free cycle
	assign apb_go  = apb_req && !(is_win && req_i.valid);
	assign apb_wr  = apb_go && pwrite_i;

	assign core_acc = req_i.valid && (req_i.op != op_load_bank);

	always_comb
	begin
		case (paddr_i)
			REG_BANK_SEL,
			REG_STATUS,
			REG_LAST_ADDR,
			REG_WIN_ADDR,
			REG_WIN_DATA,
			REG_ACC_CNT,
			REG_UNIMPL_CNT,
			REG_FLAGS: mapped = 1'b1;
			default:   mapped = 1'b0;
		endcase
	end

	// Storage port steering
	always_comb
	begin
		rd_addr = win_addr_q;
		wr_addr = win_addr_q;
		wr_data = pwdata_i[DATA_W-1:0];
		wr_en   = 1'b0;
		if (req_i.valid)
		begin
			case (req_i.op)
				op_read:
				begin
					rd_addr = oper_addr;
					wr_addr = oper_addr;
				end
				op_write:
				begin
					rd_addr = oper_addr;
					wr_addr = oper_addr;
					wr_data = req_i.wdata;
					wr_en   = 1'b1;
				end
				op_file_move:
				begin
					rd_addr = req_i.src;
					wr_addr = req_i.dst;
					wr_data = rd_data;
					wr_en   = 1'b1;
				end
				default:
				begin
					rd_addr = oper_addr;
					wr_addr = oper_addr;
				end
			endcase
		end
		else if (apb_wr && is_win && pstrb_i[0])
		begin
			wr_en = 1'b1;
		end
	end

	// A move is flagged when either end falls in an absent bank
	always_comb
	begin
		case (req_i.op)
			op_read:      core_unimpl = !rd_impl;
			op_write:     core_unimpl = !wr_impl;
			op_file_move: core_unimpl = !rd_impl || !wr_impl;
			default:      core_unimpl = 1'b0;
		endcase
	end

	// Bank select: the instruction wins over a same-cycle software write
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			bank_select_q <= BANK_SEL_RST;
		else if (req_i.valid && req_i.op == op_load_bank)
			bank_select_q <= req_i.lit & BANK_SEL_MASK;
		else if (apb_wr && paddr_i == REG_BANK_SEL && pstrb_i[0])
			bank_select_q <= pwdata_i[7:0] & BANK_SEL_MASK;
	end

	// Flags follow the instruction even when its bank is absent
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			flags_q <= FLAGS_RST;
		else if (req_i.valid && req_i.flags_we)
			flags_q <= req_i.flags;
	end

	// Answer to the decode stage, one cycle after the request
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rsp_q <= '0;
		end
		else
		begin
			rsp_q.valid <= core_acc;
			if (core_acc)
			begin
				rsp_q.addr   <= (req_i.op == op_file_move) ? req_i.dst : rd_addr;
				rsp_q.rdata  <= rd_data;
				rsp_q.unimpl <= core_unimpl;
			end
		end
	end

	// Window address for software access to the data space
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			win_addr_q <= '0;
		else if (apb_wr && paddr_i == REG_WIN_ADDR)
		begin
			if (pstrb_i[0])
				win_addr_q[7:0] <= pwdata_i[7:0];
			if (pstrb_i[1])
				win_addr_q[ADDR_W-1:8] <= pwdata_i[ADDR_W-1:8];
		end
	end

	// Counters: a write clears, but a same-cycle event still counts
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			acc_cnt_q <= '0;
		else if (apb_wr && paddr_i == REG_ACC_CNT)
			acc_cnt_q <= CNT_W'(core_acc);
		else if (core_acc)
			acc_cnt_q <= acc_cnt_q + 1'b1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			unimpl_cnt_q <= '0;
		else if (apb_wr && paddr_i == REG_UNIMPL_CNT)
			unimpl_cnt_q <= CNT_W'(core_acc && core_unimpl);
		else if (core_acc && core_unimpl)
			unimpl_cnt_q <= unimpl_cnt_q + 1'b1;
	end

	// APB read data
	always_comb
	begin
		rd_mux = '0;
		case (paddr_i)
			REG_BANK_SEL:   rd_mux[7:0] = bank_select_q;
			REG_STATUS:
			begin
				rd_mux[0] = rsp_q.unimpl;
				rd_mux[1] = BANK_IMPL_MASK[bank_select_q[BANK_W-1:0]];
				rd_mux[2] = BANK_IMPL_MASK[win_addr_q[ADDR_W-1 -: BANK_W]];
			end
			REG_LAST_ADDR:  rd_mux[ADDR_W-1:0] = rsp_q.addr;
			REG_WIN_ADDR:   rd_mux[ADDR_W-1:0] = win_addr_q;
			REG_WIN_DATA:   rd_mux[DATA_W-1:0] = rd_data;
			REG_ACC_CNT:    rd_mux[CNT_W-1:0]  = acc_cnt_q;
			REG_UNIMPL_CNT: rd_mux[CNT_W-1:0]  = unimpl_cnt_q;
			REG_FLAGS:      rd_mux[FLAGS_W-1:0] = flags_q;
			default:        rd_mux = '0;
		endcase
	end

	// APB handshake
	always_comb
	begin
		case (ap_state_q)
			ap_idle:
			begin
				if (apb_go)
					ap_state_d = ap_resp;
				else if (apb_req)
					ap_state_d = ap_wait;
				else
					ap_state_d = ap_idle;
			end
			ap_wait:
			begin
				if (apb_go)
					ap_state_d = ap_resp;
				else if (apb_req)
					ap_state_d = ap_wait;
				else
					ap_state_d = ap_idle;
			end
			ap_resp:  ap_state_d = ap_idle;
			default:  ap_state_d = ap_idle;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			ap_state_q <= ap_idle;
		else
			ap_state_q <= ap_state_d;
	end

	// Registered answer costs one wait state but keeps outputs glitch free
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end
		else
		begin
			pready_q  <= apb_go;
			pslverr_q <= apb_go && !mapped;
			if (apb_go && !pwrite_i)
				prdata_q <= rd_mux;
			else
				prdata_q <= '0;
		end
	end

	assign prdata_o       = prdata_q;
	assign pready_o       = pready_q;
	assign pslverr_o      = pslverr_q;
	assign rsp_o          = rsp_q;
	assign bank_select_o  = bank_select_q;
	assign status_flags_o = flags_q;

endmodule

// [tb/dmba_asserts.sv]
// dmba_asserts.sv: timing and mapping properties on the top module's ports
// Assumes one clock domain and a decode stage that offers one request per cycle
`timescale 1ns/100ps
module dmba_asserts
	import dmba_pkg::*;
(
	// Clock and reset
	input  wire logic               mclk_i,
	input  wire logic               rst_i,
	// Core side
	input  wire dmba_req_t          req_i,
	input  wire dmba_rsp_t          rsp_o,
	// Visible state
	input  wire logic [7:0]         bank_select_o,
	input  wire logic [FLAGS_W-1:0] status_flags_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	logic rw;
	assign rw = req_i.valid && (req_i.op == op_read || req_i.op == op_write);

	property p_bank_addr;
		rw && req_i.use_bank |=> rsp_o.valid &&
			rsp_o.addr == {$past(bank_select_o[3:0]), $past(req_i.offset)};
	endproperty
	property p_common_lo;
		rw && !req_i.use_bank && !req_i.offset[7] |=> rsp_o.addr == {4'h0, $past(req_i.offset)};
	endproperty
	property p_common_hi;
		rw && !req_i.use_bank && req_i.offset[7] |=> rsp_o.addr == {4'hf, $past(req_i.offset)};
	endproperty
	property p_move;
		req_i.valid && req_i.op == op_file_move |=> rsp_o.valid && rsp_o.addr == $past(req_i.dst);
	endproperty
	property p_load;
		req_i.valid && req_i.op == op_load_bank |=>
			!rsp_o.valid && bank_select_o == {4'h0, $past(req_i.lit[3:0])};
	endproperty
	property p_upper;
		bank_select_o[7:4] == 4'h0;
	endproperty
	property p_absent;
		rsp_o.valid && rsp_o.unimpl && $past(req_i.op) == op_read |-> rsp_o.rdata == 8'h00;
	endproperty
	property p_unimpl;
		rw |=> rsp_o.unimpl == !BANK_IMPL_MASK[rsp_o.addr[11:8]];
	endproperty
	property p_flags;
		req_i.valid && req_i.flags_we |=> status_flags_o == $past(req_i.flags);
	endproperty

	a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");
	a_common_lo: assert property (p_common_lo) else $error("common low address wrong");
	a_common_hi: assert property (p_common_hi) else $error("common high address wrong");
	a_move: assert property (p_move) else $error("move address wrong");
	a_load: assert property (p_load) else $error("bank load wrong");
	a_upper: assert property (p_upper) else $error("bank upper nibble set");
	a_absent: assert property (p_absent) else $error("absent bank read nonzero");
	a_unimpl: assert property (p_unimpl) else $error("absent flag wrong");
	a_flags: assert property (p_flags) else $error("flags not updated");

	c_absent: cover property (rsp_o.valid && rsp_o.unimpl);
	c_high: cover property (rw && !req_i.use_bank && req_i.offset[7]);
	c_move: cover property (req_i.valid && req_i.op == op_file_move);
endmodule

// [tb/dmba_core_model.sv]
// dmba_core_model.sv: decode stage stand-in, offers one request per call
// Assumes the caller is between clock edges; request stands exactly one cycle
`timescale 1ns/100ps
module dmba_core_model
	import dmba_pkg::*;
(
	input  wire logic mclk_i,
	output dmba_req_t req_o
);
	initial req_o = '0;

	// Returns at the edge that takes the request; the answer follows it
	task issue(input dmba_req_t r);
		@(posedge mclk_i);
		req_o <= r;
		@(posedge mclk_i);
		req_o <= '0;
	endtask
endmodule

// [tb/dmba_top_bench.sv]
// dmba_top_bench.sv: self-checking bench for the addressing block
// Assumes APB and core requests on one 100 MHz clock, never in the same cycle
`timescale 1ns/100ps
module dmba_top_bench
	import dmba_pkg::*;
;
	logic               mclk_i;
	logic               rst_i;
	logic [11:0]        paddr;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [31:0]        pwdata;
	logic [31:0]        prdata_o;
	logic               pready_o;
	logic               pslverr_o;
	dmba_req_t          req;
	dmba_rsp_t          rsp_o;
	logic [7:0]         bank_select_o;
	logic [FLAGS_W-1:0] status_flags_o;
	int                 mismatches = 0;
	int                 checked = 0;
	logic [15:0]        seed = 16'h002e;
	logic [3:0]         bank_q;
	logic [7:0]         mem [4096];
	logic [31:0]        q;
	logic               e;
	logic [3:0]         pstrb;
	int                 acc_n = 0;
	int                 abs_n = 0;
	logic               lu = 1'b0;
	logic [11:0]        la = 12'h000;
	logic [FLAGS_W-1:0] flg = '0;

	dmba_core_model core (.mclk_i(mclk_i), .req_o(req));
	dmba_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .req_i(req),
		.rsp_o(rsp_o), .bank_select_o(bank_select_o), .status_flags_o(status_flags_o));

	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	function logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction

	function logic impl(input logic [11:0] a);
		return BANK_IMPL_MASK[a[11:8]];
	endfunction

	// Absent banks read zero, so the shadow is only consulted for implemented ones
	function logic [7:0] rd_mem(input logic [11:0] a);
		return impl(a) ? mem[a] : 8'h00;
	endfunction

	task finish_test();
		if (mismatches == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do @(posedge mclk_i); while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task do_req(input dmba_op_t o, input logic ub, input logic [7:0] off, input logic [11:0] s, d);
		dmba_req_t   r;
		logic [11:0] a;
		logic [7:0]  ex;
		r = '0;
		r.valid = 1'b1;
		r.op = o;
		r.use_bank = ub;
		r.offset = off;
		r.lit = off;
		r.src = s;
		r.dst = d;
		r.wdata = 8'(rnd());
		r.flags = seed[12:8];
		r.flags_we = seed[15];
		a = (o == op_file_move) ? d : ub ? {bank_q, off} : {{4{off[7]}}, off};
		ex = rd_mem((o == op_file_move) ? s : a);
		core.issue(r);
		#1;
		if (o == op_load_bank)
		begin
			bank_q = off[3:0];
			chk(32'(bank_select_o), {28'h0, off[3:0]});
		end
		else
			chk({19'h0, rsp_o.valid, rsp_o.addr}, {20'h1, a});
		if (o == op_read || o == op_file_move)
			chk(32'(rsp_o.rdata), 32'(ex));
		if (o == op_read)
			chk(32'(rsp_o.unimpl), 32'(!impl(a)));
		if (o == op_write && impl(a))
			mem[a] = r.wdata;
		if (o == op_file_move && impl(d))
			mem[d] = ex;
		if (r.flags_we)
		begin
			flg = r.flags;
			chk(32'(status_flags_o), 32'(r.flags));
		end
		// Shadow of what the counters and report registers should hold
		if (o != op_load_bank)
		begin
			acc_n++;
			la = a;
			lu = (o == op_file_move) ? (!impl(s) || !impl(d)) : !impl(a);
			if (lu)
				abs_n++;
		end
	endtask

	initial
	begin
		rst_i = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		bank_q = 4'h0;
		foreach (mem[i])
			mem[i] = 8'h00;
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		chk(32'(bank_select_o), 32'h0);
		apb(1'b1, REG_BANK_SEL, 32'h0000_00a5);
		apb(1'b0, REG_BANK_SEL, 32'h0);
		bank_q = 4'h5;
		chk(q, 32'h0000_0005);
		// Without lane 0 the bank select write must be dropped
		pstrb <= 4'he;
		apb(1'b1, REG_BANK_SEL, 32'h0000_000a);
		pstrb <= 4'hf;
		apb(1'b0, REG_BANK_SEL, 32'h0);
		chk(q, 32'h0000_0005);
		apb(1'b0, 12'h020, 32'h0);
		chk(32'(e), 32'h1);
		// Common region written while an absent bank is selected
		for (int i = 0; i < 4; i++)
			do_req(op_write, 1'b0, 8'(8'h7e + i), 12'h0, 12'h0);
		for (int i = 0; i < 4; i++)
		begin
			do_req(op_load_bank, 1'b0, (i < 2) ? 8'h00 : 8'h0f, 12'h0, 12'h0);
			do_req(op_read, 1'b1, 8'(8'h7e + i), 12'h0, 12'h0);
		end
		for (int b = 0; b < 16; b++)
		begin
			q = 32'(rnd());
			do_req(op_load_bank, 1'b0, {q[7:4], 4'(b)}, 12'h0, 12'h0);
			e = b[0];
			q = e ? 32'h0000_00ff : 32'(rnd());
			do_req(op_write, 1'b1, q[7:0], 12'h0, 12'h0);
			do_req(op_read, 1'b1, q[7:0], 12'h0, 12'h0);
		end
		do_req(op_file_move, 1'b1, 8'h00, 12'hfff, 12'h105);
		do_req(op_file_move, 1'b0, 8'h00, 12'h105, 12'h07d);
		do_req(op_file_move, 1'b1, 8'h00, 12'h3aa, 12'h010);
		do_req(op_read, 1'b0, 8'h7d, 12'h0, 12'h0);
		do_req(op_read, 1'b0, 8'h10, 12'h0, 12'h0);
		// Report registers follow the core traffic
		apb(1'b0, REG_ACC_CNT, 32'h0);
		chk(q, 32'(acc_n));
		apb(1'b0, REG_UNIMPL_CNT, 32'h0);
		chk(q, 32'(abs_n));
		apb(1'b0, REG_LAST_ADDR, 32'h0);
		chk(q, 32'(la));
		apb(1'b0, REG_FLAGS, 32'h0);
		chk(q, 32'(flg));
		apb(1'b1, REG_WIN_ADDR, 32'h0000_0105);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, {29'h0, impl(12'h105), BANK_IMPL_MASK[bank_q], lu});
		// Data window into an implemented and an absent bank
		apb(1'b0, REG_WIN_DATA, 32'h0);
		chk(q, 32'(rd_mem(12'h105)));
		apb(1'b1, REG_WIN_DATA, 32'h0000_005a);
		mem[12'h105] = 8'h5a;
		apb(1'b0, REG_WIN_DATA, 32'h0);
		chk(q, 32'h0000_005a);
		apb(1'b1, REG_WIN_ADDR, 32'h0000_03aa);
		apb(1'b1, REG_WIN_DATA, 32'h0000_00c3);
		apb(1'b0, REG_WIN_DATA, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, REG_ACC_CNT, 32'h0);
		apb(1'b0, REG_ACC_CNT, 32'h0);
		chk(q, 32'h0);
		// A second reset in mid-run clears storage as well as registers
		@(posedge mclk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk(32'(bank_select_o), 32'h0);
		chk(32'(status_flags_o), 32'h0);
		chk({10'h0, rsp_o}, 32'h0);
		foreach (mem[i])
			mem[i] = 8'h00;
		bank_q = 4'h0;
		do_req(op_read, 1'b0, 8'h7e, 12'h0, 12'h0);
		do_req(op_read, 1'b0, 8'hff, 12'h0, 12'h0);
		finish_test();
	end

	initial
	begin
		repeat (5000) @(posedge mclk_i);
		mismatches++;
		finish_test();
	end
endmodule

bind dmba_top dmba_asserts u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
	.rsp_o(rsp_o), .bank_select_o(bank_select_o), .status_flags_o(status_flags_o));
